// *** hdl/mal_top.sv ***
// Purpose: Execution datapath for pointer add, AND, add, add-with-carry, shift, bit clear
// Assumes: Decoder presents the word with the addressed file byte in the same cycle
// Notes: Working register, flags and pointers are also reachable over Avalon-MM
`timescale 1ns/1ns
`include "mal_cfg.svh"

module mal_top
  import mal_pkg::*;
(
  // Clock, reset, enable
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  // Instruction issue from the decoder
  input wire logic instr_valid,
  input wire logic [13:0] instr_word,
  input wire logic [7:0] file_rdata,
  output logic instr_ready,
  output logic instr_done,
  // Result write toward data memory
  output mal_fwr_t file_wr,
  // Avalon-MM slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);

  ////////////////////////////////////////////////////////////////////////////////
  // State
  logic [7:0] work_ff;
  mal_flags_t flags_ff;
  logic [15:0] ptr0_ff;
  logic [15:0] ptr1_ff;
  mal_state_t state_ff;
  logic ready_ff;
  logic done_ff;
  mal_fwr_t fwr_ff;
  logic [31:0] rdata_ff;
  logic wait_ff;

  logic [7:0] nxt_work;
  mal_flags_t nxt_flags;
  logic [15:0] nxt_ptr0;
  logic [15:0] nxt_ptr1;
  mal_fwr_t nxt_fwr;
  logic nxt_stall;
  mal_op_t op;
  logic [7:0] operand;
  logic [7:0] result;
  logic [8:0] sum;
  logic [4:0] low_sum;
  logic carry_in;
  logic [15:0] ptr_sum;
  logic accept;
  logic bus_hit;

  assign accept = ce && instr_valid && ready_ff;
  assign bus_hit = ce && (avs_read || avs_write) && !wait_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // Decode
  always_comb begin
    op = MAL_OP_NONE;
    if (instr_word[13:8] == `MAL_OPC_PTR_ADD && !instr_word[7]) begin
      op = MAL_OP_PTR_ADD;
    end else if (instr_word[13:8] == `MAL_OPC_LIT_AND) begin
      op = MAL_OP_LIT_AND;
    end else if (instr_word[13:8] == `MAL_OPC_LIT_ADD) begin
      op = MAL_OP_LIT_ADD;
    end else if (instr_word[13:8] == `MAL_OPC_REG_ADD) begin
      op = MAL_OP_REG_ADD;
    end else if (instr_word[13:8] == `MAL_OPC_REG_AND) begin
      op = MAL_OP_REG_AND;
    end else if (instr_word[13:8] == `MAL_OPC_ASR) begin
      op = MAL_OP_ASR;
    end else if (instr_word[13:8] == `MAL_OPC_ADDC) begin
      op = MAL_OP_ADDC;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Execute: one shared adder serves literal add, register add and add-with-carry; pointer add has its own
  always_comb begin
    logic is_lit;
    logic is_bclr;
    is_lit = (op == MAL_OP_LIT_AND) || (op == MAL_OP_LIT_ADD);
    is_bclr = (instr_word[13:10] == `MAL_OPC_BCLR);
    operand = is_lit ? instr_word[7:0] : file_rdata;
    carry_in = (op == MAL_OP_ADDC) ? flags_ff.c : 1'b0;
    sum = {1'b0, work_ff} + {1'b0, operand} + {8'h00, carry_in};
    low_sum = {1'b0, work_ff[3:0]} + {1'b0, operand[3:0]} + {4'h0, carry_in};
    // Sign extension, then plain 16-bit add that drops the carry out
    ptr_sum = (instr_word[6] ? ptr1_ff : ptr0_ff)
              + {{10{instr_word[5]}}, instr_word[5:0]};
    nxt_work = work_ff;
    nxt_flags = flags_ff;
    nxt_ptr0 = ptr0_ff;
    nxt_ptr1 = ptr1_ff;
    nxt_fwr = '{we: 1'b0, addr: instr_word[6:0], data: 8'h00};
    result = 8'h00;
    case (op)
      MAL_OP_LIT_AND, MAL_OP_REG_AND: begin
        result = work_ff & operand;
      end
      MAL_OP_LIT_ADD, MAL_OP_REG_ADD, MAL_OP_ADDC: begin
        result = sum[7:0];
        nxt_flags.c = sum[8];
        nxt_flags.dc = low_sum[4];
      end
      MAL_OP_ASR: begin
        result = {file_rdata[7], file_rdata[7:1]};
        nxt_flags.c = file_rdata[0];
      end
      default: begin
        result = 8'h00;
      end
    endcase
    if (op == MAL_OP_PTR_ADD) begin
      if (instr_word[6]) begin
        nxt_ptr1 = ptr_sum;
      end else begin
        nxt_ptr0 = ptr_sum;
      end
    end else if (is_lit) begin
      nxt_work = result;
      nxt_flags.z = (result == 8'h00);
    end else if (op != MAL_OP_NONE) begin
      nxt_flags.z = (result == 8'h00);
      // Destination bit 7: 0 to working register, 1 back to file
      if (instr_word[7]) begin
        nxt_fwr.we = 1'b1;
        nxt_fwr.data = result;
      end else begin
        nxt_work = result;
      end
    end else if (is_bclr) begin
      nxt_fwr.we = 1'b1;
      nxt_fwr.data = file_rdata & ~(8'h01 << instr_word[9:7]);
    end
    // Indirect target with pointer MSB set costs one more cycle
    nxt_stall = ((op != MAL_OP_NONE && !is_lit && op != MAL_OP_PTR_ADD) || is_bclr)
                && ((instr_word[6:0] == `MAL_IND0_ADDR && ptr0_ff[15])
                 || (instr_word[6:0] == `MAL_IND1_ADDR && ptr1_ff[15]));
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Architectural state; a bus write wins over an instruction in the same cycle
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      work_ff <= `MAL_RST_WORK;
      flags_ff <= '0;
      ptr0_ff <= `MAL_RST_PTR;
      ptr1_ff <= `MAL_RST_PTR;
    end else if (ce) begin
      if (accept) begin
        work_ff <= nxt_work;
        flags_ff <= nxt_flags;
        ptr0_ff <= nxt_ptr0;
        ptr1_ff <= nxt_ptr1;
      end
      if (bus_hit && avs_write) begin
        if (avs_address == `MAL_OFS_WORK) begin
          work_ff <= avs_writedata[7:0];
        end else if (avs_address == `MAL_OFS_STAT) begin
          flags_ff <= avs_writedata[`MAL_STAT_Z:`MAL_STAT_C];
        end else if (avs_address == `MAL_OFS_PTR0) begin
          ptr0_ff <= avs_writedata[15:0];
        end else if (avs_address == `MAL_OFS_PTR1) begin
          ptr1_ff <= avs_writedata[15:0];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Issue sequencer: ready drops for the extra indirect cycle
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_ff <= MAL_ST_RUN;
      ready_ff <= 1'b0;
      done_ff <= 1'b0;
      fwr_ff <= '0;
    end else if (ce) begin
      fwr_ff <= accept ? nxt_fwr : '0;
      case (state_ff)
        MAL_ST_RUN: begin
          ready_ff <= !(accept && nxt_stall);
          done_ff <= accept && !nxt_stall;
          if (accept && nxt_stall) begin
            state_ff <= MAL_ST_STALL;
          end
        end
        MAL_ST_STALL: begin
          ready_ff <= 1'b1;
          done_ff <= 1'b1;
          state_ff <= MAL_ST_RUN;
        end
        default: begin
          state_ff <= MAL_ST_RUN;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Avalon-MM slave: one wait cycle, then answer; unmapped reads give zero
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wait_ff <= 1'b1;
      rdata_ff <= 32'h0000_0000;
    end else if (ce) begin
      wait_ff <= !((avs_read || avs_write) && wait_ff);
      if ((avs_read || avs_write) && wait_ff) begin
        if (avs_address == `MAL_OFS_WORK) begin
          rdata_ff <= {24'h000000, work_ff};
        end else if (avs_address == `MAL_OFS_STAT) begin
          rdata_ff <= {29'h00000000, flags_ff};
        end else if (avs_address == `MAL_OFS_PTR0) begin
          rdata_ff <= {16'h0000, ptr0_ff};
        end else if (avs_address == `MAL_OFS_PTR1) begin
          rdata_ff <= {16'h0000, ptr1_ff};
        end else begin
          rdata_ff <= 32'h0000_0000;
        end
      end
    end
  end

  assign instr_ready = ready_ff;
  assign instr_done = done_ff;
  assign file_wr = fwr_ff;
  assign avs_readdata = rdata_ff;
  assign avs_waitrequest = wait_ff;

endmodule

// *** pkg/mal_cfg.svh ***
// Purpose: Offsets, field positions, opcodes and reset values for the ALU datapath
// Assumes: Included by its bare name from the top module, the monitor and the bench
// Notes: Definitions only
`ifndef MAL_CFG_SVH
`define MAL_CFG_SVH

// Register byte offsets on the Avalon-MM slave
`define MAL_OFS_WORK 4'h0
`define MAL_OFS_STAT 4'h4
`define MAL_OFS_PTR0 4'h8
`define MAL_OFS_PTR1 4'hC

// Status register bit positions
`define MAL_STAT_C 0
`define MAL_STAT_DC 1
`define MAL_STAT_Z 2

// Reset values
`define MAL_RST_WORK 8'h00
`define MAL_RST_PTR 16'h0000

// Opcode prefixes, bits 13:8 of the instruction word
`define MAL_OPC_PTR_ADD 6'h31
`define MAL_OPC_LIT_AND 6'h39
`define MAL_OPC_LIT_ADD 6'h3E
`define MAL_OPC_REG_ADD 6'h07
`define MAL_OPC_REG_AND 6'h05
`define MAL_OPC_ASR 6'h37
`define MAL_OPC_ADDC 6'h3D
// Bit-clear prefix, bits 13:10
`define MAL_OPC_BCLR 4'h4

// File addresses of the two indirect access registers
`define MAL_IND0_ADDR 7'h00
`define MAL_IND1_ADDR 7'h01

`endif

// *** pkg/mal_pkg.sv ***
// Purpose: Types shared by the ALU datapath
// Assumes: mal_cfg.svh holds the numbers
// Notes: Types only
package mal_pkg;

  // Status flags carried together
  typedef struct packed {
    logic z;
    logic dc;
    logic c;
  } mal_flags_t;

  // Write port toward data memory
  typedef struct packed {
    logic we;
    logic [6:0] addr;
    logic [7:0] data;
  } mal_fwr_t;

  // Decoded operation
  typedef enum logic [2:0] {
    MAL_OP_NONE, MAL_OP_PTR_ADD, MAL_OP_LIT_AND, MAL_OP_LIT_ADD,
    MAL_OP_REG_ADD, MAL_OP_REG_AND, MAL_OP_ASR, MAL_OP_ADDC
  } mal_op_t;

  // Issue sequencer states
  typedef enum logic {
    MAL_ST_RUN, MAL_ST_STALL
  } mal_state_t;

endpackage

// *** test/mal_top_monitor.sv ***
// Purpose: Port assertions for the ALU datapath
// Assumes: One clock domain, ce dropped only while the bus is idle
// Notes: Bound onto mal_top
`timescale 1ns/1ns
`include "mal_cfg.svh"

module mal_top_monitor
  import mal_pkg::*;
(
  // Clock, reset, enable
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  // Instruction side
  input wire logic instr_valid,
  input wire logic [13:0] instr_word,
  input wire logic [7:0] file_rdata,
  input wire logic instr_ready,
  input wire logic instr_done,
  input wire mal_fwr_t file_wr,
  // Bus side
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest
);
  default clocking mon_cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Decode helpers; file ops grouped since they share the destination bit
  wire take = ce && instr_valid && instr_ready;
  wire [5:0] opc = instr_word[13:8];
  wire [2:0] bsel = instr_word[9:7];
  wire lit = opc == `MAL_OPC_LIT_AND || opc == `MAL_OPC_LIT_ADD;
  wire regop = opc == `MAL_OPC_REG_ADD || opc == `MAL_OPC_REG_AND ||
    opc == `MAL_OPC_ADDC || opc == `MAL_OPC_ASR;
  ////////////////////////////////////////////////////////////
  a_take_done: assert property (take |=> instr_done || !instr_ready)
    else $error("taken word gave no done");
  a_stall_one: assert property ($fell(instr_ready) |=> instr_ready && instr_done)
    else $error("stall longer than one cycle");
  a_ptr_nowrite: assert property (take && opc == `MAL_OPC_PTR_ADD |=> !file_wr.we)
    else $error("pointer add wrote a file byte");
  a_lit_nowrite: assert property (take && lit |=> !file_wr.we)
    else $error("literal op wrote a file byte");
  a_dest_work: assert property (take && regop && !instr_word[7] |=> !file_wr.we)
    else $error("dest 0 wrote a file byte");
  a_dest_file: assert property (take && regop && instr_word[7] |=>
    file_wr.we && file_wr.addr == $past(instr_word[6:0])) else $error("dest 1 bad");
  a_shift_data: assert property (take && opc == `MAL_OPC_ASR && instr_word[7] |=>
    file_wr.data == (($past(file_rdata) >> 1) | ($past(file_rdata) & 8'h80)))
    else $error("shift result wrong");
  a_bclr_data: assert property (take && instr_word[13:10] == `MAL_OPC_BCLR |=>
    file_wr.we && file_wr.data == ($past(file_rdata) & ~(8'h01 << $past(bsel))))
    else $error("bit clear result wrong");
  a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=>
    !avs_waitrequest ##1 avs_waitrequest) else $error("bus answer not one cycle");
endmodule

bind mal_top mal_top_monitor u_mon (.sys_clk(sys_clk), .rst(rst), .ce(ce),
  .instr_valid(instr_valid), .instr_word(instr_word), .file_rdata(file_rdata),
  .instr_ready(instr_ready), .instr_done(instr_done), .file_wr(file_wr),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest));

// *** test/mcu_arith_logic_bitclear_ops_test.sv ***
// Purpose: Self-checking bench for the ALU datapath
// Assumes: ce dropped once with the bus idle; bench plays decoder and memory
// Notes: Expected values worked out from the operands
`timescale 1ns/1ns
`include "mal_cfg.svh"

module mcu_arith_logic_bitclear_ops_test import mal_pkg::*;;
  logic sys_clk = 1'b0, rst = 1'b1, ce = 1'b1, instr_valid = 1'b0, avs_read = 1'b0;
  logic avs_write = 1'b0, instr_ready, instr_done, avs_waitrequest, rdy, dn;
  logic [13:0] instr_word = 14'h0000;
  logic [7:0] file_rdata = 8'h00;
  logic [3:0] avs_address = 4'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
  mal_fwr_t file_wr, wr;
  int errors = 0, n_checks = 0, cyc = 0;
  // Clock, 8 ns period
  always #4 sys_clk = ~sys_clk;
  mal_top dut (.sys_clk(sys_clk), .rst(rst), .ce(ce), .instr_valid(instr_valid),
    .instr_word(instr_word), .file_rdata(file_rdata), .instr_ready(instr_ready),
    .instr_done(instr_done), .file_wr(file_wr), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  ////////////////////////////////////////////////////////////
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Bus cycle; request held until waitrequest is sampled low at a rising edge
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= d;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task rchk(input logic [3:0] a, input logic [15:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd, {16'h0000, e});
  endtask
  task wchk(input logic [15:0] e);
    chk({16'h0000, wr}, {16'h0000, e});
  endtask
  // Holds the word until ready is sampled high, then grabs write port, ready and done
  task issue(input logic [13:0] w, input logic [7:0] f);
    @(posedge sys_clk);
    instr_valid <= 1'b1;
    instr_word <= w;
    file_rdata <= f;
    do @(posedge sys_clk); while (instr_ready !== 1'b1);
    instr_valid <= 1'b0;
    @(posedge sys_clk);
    wr = file_wr;
    rdy = instr_ready;
    dn = instr_done;
  endtask
  ////////////////////////////////////////////////////////////
  task t_lit;
    rchk(`MAL_OFS_STAT, 16'h0000);
    rchk(4'h2, 16'h0000);
    bus(1'b1, `MAL_OFS_WORK, 32'h0F);
    issue({`MAL_OPC_LIT_ADD, 8'hF1}, 8'h00);
    chk({31'h0, wr.we}, 32'h0);
    chk({31'h0, dn}, 32'h1);
    rchk(`MAL_OFS_WORK, 16'h0000);
    rchk(`MAL_OFS_STAT, 16'h0007);
    bus(1'b1, `MAL_OFS_WORK, 32'h3C);
    issue({`MAL_OPC_LIT_AND, 8'h34}, 8'h00);
    rchk(`MAL_OFS_WORK, 16'h0034);
    rchk(`MAL_OFS_STAT, 16'h0003);
    $display("test literal done");
  endtask
  task t_reg;
    bus(1'b1, `MAL_OFS_WORK, 32'h88);
    issue({`MAL_OPC_REG_ADD, 8'h85}, 8'h78);
    wchk(16'h8500);
    rchk(`MAL_OFS_WORK, 16'h0088);
    rchk(`MAL_OFS_STAT, 16'h0007);
    issue({`MAL_OPC_ADDC, 8'h06}, 8'h10);
    chk({31'h0, wr.we}, 32'h0);
    rchk(`MAL_OFS_WORK, 16'h0099);
    rchk(`MAL_OFS_STAT, 16'h0000);
    issue({`MAL_OPC_REG_AND, 8'h87}, 8'h0F);
    wchk(16'h8709);
    $display("test register done");
  endtask
  task t_shift;
    issue({`MAL_OPC_ASR, 8'h09}, 8'h81);
    rchk(`MAL_OFS_WORK, 16'h00C0);
    issue({`MAL_OPC_ASR, 8'h8C}, 8'h01);
    wchk(16'h8C00);
    rchk(`MAL_OFS_STAT, 16'h0005);
    // Write port word: enable bit, then address 0x0A, then cleared data
    for (int b = 0; b < 8; b++) begin
      issue({`MAL_OPC_BCLR, b[2:0], 7'h0A}, 8'hFF);
      wchk({8'h8A, 8'hFF & ~(8'h01 << b)});
    end
    rchk(`MAL_OFS_STAT, 16'h0005);
    $display("test shift done");
  endtask
  task t_ptr;
    bus(1'b1, `MAL_OFS_PTR0, 32'h0005);
    bus(1'b1, `MAL_OFS_PTR1, 32'hFFF0);
    issue({`MAL_OPC_PTR_ADD, 2'b00, 6'h20}, 8'h00);
    issue({`MAL_OPC_PTR_ADD, 2'b01, 6'h1F}, 8'h00);
    rchk(`MAL_OFS_PTR0, 16'hFFE5);
    rchk(`MAL_OFS_PTR1, 16'h000F);
    rchk(`MAL_OFS_STAT, 16'h0005);
    // Same prefix with the zero bit set is not a pointer add
    issue({`MAL_OPC_PTR_ADD, 2'b10, 6'h01}, 8'h00);
    rchk(`MAL_OFS_PTR0, 16'hFFE5);
    issue({`MAL_OPC_REG_ADD, 8'h80}, 8'h01);
    chk({31'h0, rdy}, 32'h0);
    chk({31'h0, dn}, 32'h0);
    issue({`MAL_OPC_REG_ADD, 8'h81}, 8'h01);
    chk({31'h0, rdy}, 32'h1);
    chk({31'h0, dn}, 32'h1);
    $display("test pointer done");
  endtask
  // Clock enable low: a presented word must not be taken nor change state
  task t_freeze;
    @(posedge sys_clk);
    ce <= 1'b0;
    instr_valid <= 1'b1;
    instr_word <= {`MAL_OPC_LIT_ADD, 8'h11};
    repeat (3) @(posedge sys_clk);
    chk({31'h0, instr_done}, 32'h0);
    chk({31'h0, instr_ready}, 32'h1);
    ce <= 1'b1;
    instr_valid <= 1'b0;
    rchk(`MAL_OFS_WORK, 16'h00C0);
    $display("test freeze done");
  endtask
  ////////////////////////////////////////////////////////////
  task tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Hang guard, far above the roughly 135 cycles the tests need
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      errors++;
      tally_and_finish;
    end
  end
  // Main sequence
  initial begin
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    t_lit;
    t_reg;
    t_shift;
    t_ptr;
    t_freeze;
    tally_and_finish;
  end
endmodule
